// [ivm_vector_map.sv]
// Interrupt request collection and vector number / entry address map
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1 - Condition sets source flag bit
// R2 - Each source gated by software enable bit
// R3 - Request equals enable AND flag
// R4 - Request holds until flag cleared
// R5 - Maskable requests need global enable
// R6 - Each vector owned by one peripheral
// R7 - Reset vector 0, NMI vector 1, address 2n
// R8 - Vector 2 carries voltage level monitor
// R9 - Port vectors 3-5, C only wide variants
// R10 - Counter vector 6, periodic tick 7
// R11 - Type-A timer uses vectors 8 to 12
// R12 - Type-B timers use vectors 13, 14
// R13 - Type-D timer overflow 15, trigger 16
// R14 - Comparators 17-19, converters 20-23
// R15 - Two-wire 24, 25; serial peripheral 26
// R16 - Transceiver receive/empty/complete 27-29
// R17 - Nonvolatile controller ready is vector 30
// R18 - Lowest pending vector wins; NMI ignores enable
module ivm_vector_map (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] flag_set,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] flag_clear,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] source_enable,
  input wire logic global_enable,
  input wire logic port_c_present,
  input wire logic reset_entry_taken,
  output logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] irq_flag_register,
  output logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] irq_request,
  output logic irq_pending,
  output logic irq_nmi,
  output logic [ivm_pkg::VEC_W-1:0] irq_vector,
  output logic [ivm_pkg::ENTRY_W-1:0] irq_entry_word
);
  import ivm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word address of a vector: two words per entry
  function automatic logic [ENTRY_W-1:0] entry_of(input logic [VEC_W-1:0] vec);
    entry_of = {vec, 1'b0} << (WORDS_PER_VECTOR_SHIFT - 1); // [R7]
  endfunction : entry_of

  // True for the single non-maskable line
  function automatic logic is_nmi(input logic [VEC_W-1:0] vec);
    is_nmi = (vec == VEC_MEMORY_CRC_SCANNER); // [R7]
  endfunction : is_nmi

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic [VEC_LAST:VEC_FIRST] set_allow;
  logic [VEC_LAST:VEC_FIRST] maskable;
  logic [VEC_LAST:VEC_FIRST] eligible;
  logic found;
  logic [VEC_W-1:0] next_vector;
  ivm_state_e state;
  ivm_state_e next_state;

  // ----------------------------------------------------------------
  // Variant mask: port C line only exists on wide packages
  // ----------------------------------------------------------------
  always_comb begin
    set_allow = '1;
    set_allow[VEC_PORT_C] = port_c_present; // [R9]
  end

  // ----------------------------------------------------------------
  // Sticky source flags
  // ----------------------------------------------------------------
  ivm_flag_bank u_flags (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .flag_set(flag_set),
    .flag_clear(flag_clear),
    .set_allow(set_allow),
    .irq_flag_register(irq_flag_register)
  );

  // ----------------------------------------------------------------
  // Request formation; one line per vector, index equals vector number
  // Lines 1..30 map in table order: CRC scan, level monitor, ports A-C,
  // counter, tick, type-A timer x5, type-B x2, type-D x2, comparators x3,
  // converter 0 ready/window, converter 1 ready/window, two-wire target,
  // two-wire controller, serial peripheral, transceiver x3, nonvolatile.
  // ----------------------------------------------------------------
  assign irq_request = irq_flag_register & source_enable; // [R2] [R3] [R6]

  // Global enable gates every line except the non-maskable one
  always_comb begin
    maskable = '1;
    maskable[VEC_MEMORY_CRC_SCANNER] = 1'b0;
    eligible = irq_request & ~(maskable & {VEC_LAST{~global_enable}}); // [R5] [R18]
  end

  // ----------------------------------------------------------------
  // Lowest pending vector
  // ----------------------------------------------------------------
  ivm_lowest_pending u_pick (
    .request(eligible),
    .found(found),
    .vector(next_vector)
  );

  // ----------------------------------------------------------------
  // Reset entry sequencer: vector 0 is offered until the core takes it
  // ----------------------------------------------------------------
  always_comb begin
    case (state)
      IVM_ST_RESET_ENTRY: begin
        next_state = reset_entry_taken ? IVM_ST_RUN : IVM_ST_RESET_ENTRY;
      end
      IVM_ST_RUN: begin
        next_state = IVM_ST_RUN;
      end
      default: begin
        next_state = IVM_ST_RESET_ENTRY;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= IVM_ST_RESET_ENTRY;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Registered vector presentation to the core
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_pending <= 1'b0;
      irq_nmi <= 1'b0;
      irq_vector <= VEC_RESET;
      irq_entry_word <= ENTRY_RESET;
    end else if (clk_en) begin
      if (next_state == IVM_ST_RESET_ENTRY) begin
        irq_pending <= 1'b1;
        irq_nmi <= 1'b0;
        irq_vector <= VEC_RESET; // [R7]
        irq_entry_word <= entry_of(VEC_RESET); // [R7]
      end else begin
        irq_pending <= found; // [R4]
        irq_nmi <= found && is_nmi(next_vector); // [R18]
        irq_vector <= next_vector; // [R8] [R10] [R11] [R12] [R13]
        irq_entry_word <= entry_of(next_vector); // [R14] [R15] [R16] [R17]
      end
    end
  end

endmodule : ivm_vector_map
`default_nettype wire

// [ivm_pkg.sv]
// Shared constants for the interrupt request vector map
`default_nettype none
package ivm_pkg;

  // ----------------------------------------------------------------
  // Vector table geometry
  // ----------------------------------------------------------------
  localparam int VEC_FIRST = 1;
  localparam int VEC_LAST = 30;
  localparam int VEC_W = 5;
  localparam int ENTRY_W = 6;
  localparam int WORDS_PER_VECTOR_SHIFT = 1;

  // ----------------------------------------------------------------
  // Vector numbers: reset, then peripheral request lines, with only the first line named for comparators and converters
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;
  localparam logic [VEC_W-1:0] VEC_MEMORY_CRC_SCANNER = 5'h01;
  localparam logic [VEC_W-1:0] VEC_VOLTAGE_LEVEL_MONITOR = 5'h02;
  localparam logic [VEC_W-1:0] VEC_PORT_A = 5'h03;
  localparam logic [VEC_W-1:0] VEC_PORT_B = 5'h04;
  localparam logic [VEC_W-1:0] VEC_PORT_C = 5'h05;
  localparam logic [VEC_W-1:0] VEC_RTC_COUNTER = 5'h06;
  localparam logic [VEC_W-1:0] VEC_PERIODIC_TICK = 5'h07;
  localparam logic [VEC_W-1:0] VEC_TA_LOW_UNDERFLOW = 5'h08;
  localparam logic [VEC_W-1:0] VEC_TA_HIGH_UNDERFLOW = 5'h09;
  localparam logic [VEC_W-1:0] VEC_TA_COMPARE_CHANNEL_ZERO = 5'h0a;
  localparam logic [VEC_W-1:0] VEC_TA_COMPARE_ONE = 5'h0b;
  localparam logic [VEC_W-1:0] VEC_TA_COMPARE_TWO = 5'h0c;
  localparam logic [VEC_W-1:0] VEC_TIMER_TYPE_B_FIRST = 5'h0d;
  localparam logic [VEC_W-1:0] VEC_TIMER_TYPE_B_SECOND = 5'h0e;
  localparam logic [VEC_W-1:0] VEC_TD_OVERFLOW_EVENT = 5'h0f;
  localparam logic [VEC_W-1:0] VEC_TD_TRIGGER_REQUEST = 5'h10;
  localparam logic [VEC_W-1:0] VEC_COMPARATOR_FIRST = 5'h11;
  localparam logic [VEC_W-1:0] VEC_CONVERTER_FIRST = 5'h14;
  localparam logic [VEC_W-1:0] VEC_TWO_WIRE_TARGET_REQUEST = 5'h18;
  localparam logic [VEC_W-1:0] VEC_TWO_WIRE_CONTROLLER_REQUEST = 5'h19;
  localparam logic [VEC_W-1:0] VEC_SERIAL_PERIPHERAL = 5'h1a;
  localparam logic [VEC_W-1:0] VEC_RECEIVE_COMPLETE = 5'h1b;
  localparam logic [VEC_W-1:0] VEC_TRANSMIT_BUFFER_EMPTY = 5'h1c;
  localparam logic [VEC_W-1:0] VEC_TRANSMIT_COMPLETE = 5'h1d;
  localparam logic [VEC_W-1:0] VEC_NONVOLATILE_CONTROLLER = 5'h1e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [VEC_LAST:VEC_FIRST] FLAGS_RESET = 30'h0000_0000;
  localparam logic [ENTRY_W-1:0] ENTRY_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Reset entry sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IVM_ST_RESET_ENTRY = 2'b01,
    IVM_ST_RUN = 2'b10
  } ivm_state_e;

endpackage : ivm_pkg
`default_nettype wire

// [ivm_flag_bank.sv]
// Sticky per-source interrupt flags with set-over-clear priority
`timescale 1ns/1ns
`default_nettype none
module ivm_flag_bank (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] flag_set,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] flag_clear,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] set_allow,
  output logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] irq_flag_register
);
  import ivm_pkg::*;

  // ----------------------------------------------------------------
  // One flag per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = VEC_FIRST; g <= VEC_LAST; g = g + 1) begin : g_flag
      // Condition sets the flag; a set in the clear cycle wins
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          irq_flag_register[g] <= FLAGS_RESET[g];
        end else if (clk_en) begin
          if (flag_set[g] && set_allow[g]) begin
            irq_flag_register[g] <= 1'b1; // [R1]
          end else if (flag_clear[g]) begin
            irq_flag_register[g] <= 1'b0; // [R4]
          end
        end
      end
    end
  endgenerate

endmodule : ivm_flag_bank
`default_nettype wire

// [ivm_lowest_pending.sv]
// Picks the lowest-numbered asserted request line
`timescale 1ns/1ns
`default_nettype none
module ivm_lowest_pending (
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] request,
  output logic found,
  output logic [ivm_pkg::VEC_W-1:0] vector
);
  import ivm_pkg::*;

  // ----------------------------------------------------------------
  // Priority search, highest index first so the lowest wins
  // ----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    vector = VEC_RESET;
    for (int i = VEC_LAST; i >= VEC_FIRST; i--) begin
      if (request[i]) begin
        found = 1'b1;
        vector = VEC_W'(i); // [R18]
      end
    end
  end

endmodule : ivm_lowest_pending
`default_nettype wire

// [ivm_vector_map_checker.sv]
// Concurrent checks on the vector map ports
`timescale 1ns/1ns
`default_nettype none
module ivm_vector_map_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] flag_set,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] flag_clear,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] source_enable,
  input wire logic global_enable,
  input wire logic port_c_present,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] irq_flag_register,
  input wire logic [ivm_pkg::VEC_LAST:ivm_pkg::VEC_FIRST] irq_request,
  input wire logic irq_pending,
  input wire logic irq_nmi,
  input wire logic [ivm_pkg::VEC_W-1:0] irq_vector,
  input wire logic [ivm_pkg::ENTRY_W-1:0] irq_entry_word
);
  import ivm_pkg::*;
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_request_and_gate: assert property (irq_request == (irq_flag_register & source_enable))
    else $error("request differs from flag and enable");
  a_flag_set_seen: assert property (clk_en && flag_set[9] |=> irq_flag_register[9])
    else $error("flag did not set");
  a_flag_hold: assert property (clk_en && irq_flag_register[9] && !flag_clear[9] |=> irq_flag_register[9])
    else $error("flag dropped without clear");
  a_portc_block: assert property (clk_en && !port_c_present && !irq_flag_register[5] |=> !irq_flag_register[5])
    else $error("port c flag set on narrow part");
  a_global_mask: assert property (irq_pending && irq_vector > 5'h01 && $past(clk_en) |-> $past(global_enable))
    else $error("maskable vector offered while disabled");
  a_entry_double: assert property (irq_entry_word == {irq_vector, 1'b0})
    else $error("entry word is not twice the vector");
  a_nmi_flag: assert property (irq_nmi == (irq_pending && irq_vector == 5'h01))
    else $error("non-maskable flag wrong");
  a_lowest_pick: assert property (irq_pending && irq_vector != 5'h00 && $past(clk_en) |->
    (($past(irq_request) & ((30'h1 << irq_vector) - 30'h1)) == (30'h1 << (irq_vector - 5'h01))))
    else $error("offered vector is not the lowest request");
endmodule : ivm_vector_map_checker
bind ivm_vector_map ivm_vector_map_checker u_chk (.ref_clk, .sys_rst, .clk_en, .flag_set, .flag_clear,
  .source_enable, .global_enable, .port_c_present, .irq_flag_register, .irq_request, .irq_pending,
  .irq_nmi, .irq_vector, .irq_entry_word);
`default_nettype wire

// [ivm_core_model.sv]
// Core side model: fetches the reset entry after a set delay
`timescale 1ns/1ns
`default_nettype none
module ivm_core_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic irq_pending,
  input wire logic [ivm_pkg::VEC_W-1:0] irq_vector,
  input wire logic [3:0] delay,
  output logic reset_entry_taken
);
  import ivm_pkg::*;
  logic [3:0] cnt;
  // Pulse taken once the reset entry has been offered for delay plus one cycles
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      reset_entry_taken <= 1'b0;
    end else begin
      reset_entry_taken <= 1'b0;
      if (irq_pending && irq_vector == VEC_RESET && !reset_entry_taken) begin
        cnt <= (cnt == delay) ? 4'h0 : cnt + 4'h1;
        reset_entry_taken <= (cnt == delay);
      end
    end
  end
endmodule : ivm_core_model
`default_nettype wire

// [tb_ivm_vector_map.sv]
// Self-checking bench for the interrupt vector map
`timescale 1ns/1ns
`default_nettype none
module tb_ivm_vector_map;
  import ivm_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic global_enable = 1'b0;
  logic port_c_present = 1'b1;
  logic [VEC_LAST:VEC_FIRST] flag_set = '0;
  logic [VEC_LAST:VEC_FIRST] flag_clear = '0;
  logic [VEC_LAST:VEC_FIRST] source_enable = '0;
  logic [VEC_LAST:VEC_FIRST] irq_flag_register, irq_request, a;
  logic irq_pending, irq_nmi, reset_entry_taken, seen;
  logic [VEC_W-1:0] irq_vector;
  logic [ENTRY_W-1:0] irq_entry_word;
  logic [3:0] delay = 4'h0;
  logic [31:0] rnd = 32'hca88;
  logic [10:0] exp_q[$];
  int errors = 0;
  int cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  ivm_vector_map dut (.ref_clk, .sys_rst, .clk_en, .flag_set, .flag_clear, .source_enable, .global_enable,
    .port_c_present, .reset_entry_taken, .irq_flag_register, .irq_request, .irq_pending, .irq_nmi,
    .irq_vector, .irq_entry_word);
  ivm_core_model core (.ref_clk, .sys_rst, .irq_pending, .irq_vector, .delay, .reset_entry_taken);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [10:0] got, input logic [10:0] want);
    cmp_count++;
    if (got !== want) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Expected {vector, entry}; zero when nothing may be offered
  function automatic logic [10:0] pick(input logic [30:1] s, input logic [30:1] e, input logic g, input logic p);
    for (int i = 1; i <= 30; i++)
      if (s[i] && e[i] && (p || i != 5) && (g || i == 1)) return {i[4:0], i[4:0], 1'b0};
    return 11'h000;
  endfunction : pick
  task automatic do_reset(input logic [3:0] d);
    int n;
    sys_rst <= 1'b1;
    delay <= d;
    exp_q.push_back(11'h000);
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Let the reset entry appear first, then wait until the core has taken it
    repeat (2) @(posedge ref_clk);
    for (n = 0; n < 30 && irq_pending !== 1'b0; n++) @(posedge ref_clk);
    if (n == 30) begin
      errors++;
      end_of_test();
    end
  endtask : do_reset
  task automatic run(input logic [30:1] s, input logic [30:1] e, input logic g, input logic p, input logic c);
    logic [10:0] x;
    x = c ? pick(s, e, g, p) : 11'h000;
    if (x != 11'h000) exp_q.push_back(x);
    @(posedge ref_clk);
    source_enable <= e;
    global_enable <= g;
    port_c_present <= p;
    clk_en <= c;
    flag_set <= s;
    @(posedge ref_clk);
    flag_set <= '0;
    clk_en <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(irq_pending, x != 11'h000);
    chk(irq_vector, x[10:6]);
    chk(irq_nmi, x[10:6] == 5'h01);
    flag_clear <= '1;
    @(posedge ref_clk);
    flag_clear <= '0;
    repeat (3) @(posedge ref_clk);
    chk(irq_pending, 1'b0);
    $display("Test done at %0t", $time);
  endtask : run
  // Compare each newly offered vector with the oldest note
  always @(posedge ref_clk) begin
    if (sys_rst) seen <= 1'b0;
    else begin
      if (irq_pending === 1'b1 && seen !== 1'b1) chk({irq_vector, irq_entry_word}, exp_q.pop_front());
      seen <= irq_pending;
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    do_reset(4'h0);
    for (int v = 1; v <= 30; v++) run(30'h1 << (v - 1), '1, 1'b1, 1'b1, 1'b1);
    run(30'h101, '1, 1'b0, 1'b1, 1'b1);
    run(30'h100, '1, 1'b0, 1'b1, 1'b1);
    run(30'h30, '1, 1'b1, 1'b0, 1'b1);
    run(30'h80800, '1, 1'b1, 1'b1, 1'b1);
    run(30'h100, '0, 1'b1, 1'b1, 1'b1);
    run(30'h100, '1, 1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 12; k++) begin
      rnd = xs(rnd);
      a = rnd[29:0];
      rnd = xs(rnd);
      run(a, rnd[29:0], rnd[30], rnd[31], 1'b1);
    end
    do_reset(4'h5);
    run(30'h2000_0000, '1, 1'b1, 1'b1, 1'b1);
    chk(11'(exp_q.size()), 11'h000);
    end_of_test();
  end
endmodule : tb_ivm_vector_map
`default_nettype wire
